// ### uart_tx.v
// transmit path of an asynchronous serial port: registers, store, shifter
// assumes a plain register port with read data one cycle after the strobe
//
// How it works
// RULE1 - eight-bit shifter fed from sixteen-byte store
// RULE2 - each bit lasts 16, 8 or 4 ticks; here a start bit loaded from idle may be up to one tick short
// RULE3 - start, data, optional parity, then stop bits
// RULE4 - data bits go out LSB first
// RULE5 - bytes enter only via write-only holding register
// RULE6 - FIFO enable bit selects sixteen-entry store; here the store plus the two-entry buffer hold 18 bytes ahead of the shifter
// RULE7 - each holding write advances the write pointer (a refused one leaves it alone)
// RULE8 - status bits 5 and 6 report store/shifter
// RULE9 - divisor is integer plus fraction over sixteen
// RULE10 - fraction bits 5:4 pick oversampling rate
// RULE11 - non-FIFO: bit5 on transfer, bit6 when idle
// RULE12 - FIFO: bit5 FIFO empty, bit6 all empty
// RULE13 - divisor resets to one
// RULE14 - line idles high between characters
// RULE15 - next byte follows stop bits without gap
`timescale 1ns/10ps
`include "uart_tx_consts.vh"
module uart_tx #(
  parameter FIFO_DEPTH = 16,
  parameter FIFO_AW = 4
) (
  input wire clk_i,
  input wire rst_i,
  input wire [2:0] addr_i,
  input wire [7:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output reg [7:0] rdata_o,
  output reg tx_o,
  output wire hold_empty_o,
  output wire tx_empty_o
);
  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_START = 3'h1;
  localparam [2:0] ST_DATA = 3'h2;
  localparam [2:0] ST_PARITY = 3'h3;
  localparam [2:0] ST_STOP = 3'h4;

  // ==========================================================
  // software registers
  reg [7:0] fifo_control;
  reg [7:0] line_control;
  reg [7:0] divisor_low;
  reg [7:0] divisor_high_byte;
  reg [7:0] divisor_fraction;
  reg flush;

  wire fifo_en;
  wire [1:0] word_len;
  wire stop2;
  wire par_en;
  wire par_even;
  // line config and divisor act live; change them only while idle
  wire [1:0] mode;

  assign fifo_en = fifo_control[`FC_FIFO_EN];
  assign word_len = line_control[`LC_LEN_HI:`LC_LEN_LO];
  assign stop2 = line_control[`LC_STOP2];
  assign par_en = line_control[`LC_PAR_EN];
  assign par_even = line_control[`LC_PAR_EVEN];
  assign mode = divisor_fraction[`DF_MODE_HI:`DF_MODE_LO];

  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      fifo_control <= `RST_FIFO_CONTROL;
      line_control <= `RST_LINE_CONTROL;
      divisor_low <= `RST_DIVISOR_LOW; // [RULE13]
      divisor_high_byte <= `RST_DIVISOR_HIGH_BYTE; // [RULE13]
      divisor_fraction <= `RST_DIVISOR_FRACTION; // [RULE13]
      flush <= 1'b0;
    end else begin
      // flush lasts one cycle
      flush <= 1'b0;
      if (wr_i) begin
        case (addr_i)
          `OFS_FIFO_CONTROL: begin
            fifo_control <= wdata_i;
            // switching store mode discards queued bytes
            flush <= (wdata_i[`FC_FIFO_EN] != fifo_en);
          end
          `OFS_LINE_CONTROL: begin
            line_control <= wdata_i;
          end
          `OFS_DIVISOR_LOW: begin
            divisor_low <= wdata_i;
          end
          `OFS_DIVISOR_HIGH_BYTE: begin
            divisor_high_byte <= wdata_i;
          end
          `OFS_DIVISOR_FRACTION: begin
            divisor_fraction <= {2'b00, wdata_i[5:0]};
          end
          default: begin
          end
        endcase
      end
    end
  end

  // ==========================================================
  // oversampling tick
  // integer part zero behaves as a divisor of one
  wire tick;

  uart_tx_baud u_baud (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .div_int_i({divisor_high_byte, divisor_low}),
    .div_frac_i(divisor_fraction[`DF_FRAC_HI:`DF_FRAC_LO]),
    .tick_o(tick)
  );

  // mode 11 falls back to sixteen ticks per bit
  reg [4:0] ticks_per_bit;

  always @* begin
    case (mode)
      `MODE_8X: ticks_per_bit = `TICKS_8X; // [RULE10]
      `MODE_4X: ticks_per_bit = `TICKS_4X; // [RULE10]
      default: ticks_per_bit = `TICKS_16X; // [RULE10]
    endcase
  end

  // ==========================================================
  // transmit store and two-entry buffer ahead of the shifter
  wire store_in_ready;
  wire store_out_valid;
  wire [7:0] store_out_data;
  wire [FIFO_AW:0] store_count;
  wire buf_in_ready;
  wire buf_out_valid;
  wire [7:0] buf_out_data;
  wire [1:0] buf_count;
  wire hold_write;
  wire hold_accept;
  wire store_empty;
  wire load;

  // a refused holding write leaves the pointers alone
  assign hold_write = wr_i && (addr_i == `OFS_TRANSMIT_HOLDING); // [RULE5]
  // store and buffer together count as the transmit store
  assign store_empty = (store_count == {(FIFO_AW+1){1'b0}}) && (buf_count == 2'b00);
  // without the FIFO only a single byte may wait ahead of the shifter
  assign hold_accept = hold_write && (fifo_en ? store_in_ready : store_empty); // [RULE6]

  uart_tx_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) u_store (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .flush_i(flush),
    .in_valid_i(hold_accept), // [RULE7]
    .in_ready_o(store_in_ready),
    .in_data_i(wdata_i),
    .out_valid_o(store_out_valid),
    .out_ready_i(buf_in_ready),
    .out_data_o(store_out_data),
    .count_o(store_count)
  ); // [RULE1]

  // two entries keep the store feeding while the shifter stalls
  uart_tx_fifo #(
    .WIDTH(8),
    .DEPTH(2),
    .AW(1)
  ) u_buf (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .flush_i(flush),
    .in_valid_i(store_out_valid),
    .in_ready_o(buf_in_ready),
    .in_data_i(store_out_data),
    .out_valid_o(buf_out_valid),
    .out_ready_i(load),
    .out_data_o(buf_out_data),
    .count_o(buf_count)
  );

  // ==========================================================
  // serialiser
  reg [2:0] state;
  reg [7:0] tx_shift_reg;
  reg [4:0] tick_cnt;
  reg [2:0] bit_idx;
  reg stop_idx;
  reg parity_bit;

  wire bit_done;
  wire last_stop;
  wire [2:0] last_data;
  wire [7:0] data_mask;
  wire [7:0] masked;

  assign bit_done = tick && (tick_cnt == ticks_per_bit - 5'h01); // [RULE2]
  assign last_stop = (stop_idx == stop2);
  assign last_data = {1'b1, word_len};
  assign data_mask = 8'hFF >> (2'h3 - word_len);
  // bits above the word length are cleared before loading
  assign masked = buf_out_data & data_mask;
  // loading on the last stop tick chains characters without a gap
  assign load = buf_out_valid && !flush &&
    ((state == ST_IDLE) || ((state == ST_STOP) && bit_done && last_stop)); // [RULE15]

  // tick counter restarts at load while ticks free-run,
  // so the start bit may be up to one tick short
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state <= ST_IDLE;
      tx_shift_reg <= 8'h00;
      tick_cnt <= 5'h00;
      bit_idx <= 3'h0;
      stop_idx <= 1'b0;
      parity_bit <= 1'b0;
      tx_o <= 1'b1;
    end else if (load) begin
      tx_shift_reg <= masked;
      // odd parity unless the even bit is set
      parity_bit <= par_even ? ^masked : ~^masked;
      state <= ST_START;
      tick_cnt <= 5'h00;
      tx_o <= 1'b0; // [RULE3]
    end else begin
      if (bit_done) begin
        tick_cnt <= 5'h00;
      end else if (tick) begin
        tick_cnt <= tick_cnt + 5'h01;
      end
      case (state)
        ST_IDLE: begin
          tx_o <= 1'b1; // [RULE14]
        end
        ST_START: begin
          if (bit_done) begin
            state <= ST_DATA;
            bit_idx <= 3'h0;
            tx_o <= tx_shift_reg[0]; // [RULE4]
          end
        end
        ST_DATA: begin
          if (bit_done) begin
            if (bit_idx == last_data) begin
              state <= par_en ? ST_PARITY : ST_STOP; // [RULE3]
              tx_o <= par_en ? parity_bit : 1'b1;
              stop_idx <= 1'b0;
            end else begin
              // next bit is taken before the shift lands
              tx_shift_reg <= {1'b0, tx_shift_reg[7:1]};
              tx_o <= tx_shift_reg[1]; // [RULE4]
              bit_idx <= bit_idx + 3'h1;
            end
          end
        end
        ST_PARITY: begin
          if (bit_done) begin
            state <= ST_STOP;
            stop_idx <= 1'b0;
            tx_o <= 1'b1;
          end
        end
        ST_STOP: begin
          if (bit_done) begin
            if (last_stop) begin
              state <= ST_IDLE;
              tx_o <= 1'b1; // [RULE14]
            end else begin
              stop_idx <= 1'b1;
            end
          end
        end
        default: begin
          state <= ST_IDLE;
          tx_o <= 1'b1;
        end
      endcase
    end
  end

  // ==========================================================
  // status and read port
  // the bytes ahead of the shifter count as the store in both modes
  assign hold_empty_o = store_empty; // [RULE8] [RULE11] [RULE12]
  assign tx_empty_o = store_empty && (state == ST_IDLE); // [RULE8] [RULE11] [RULE12]

  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o <= 8'h00;
    end else if (rd_i) begin
      case (addr_i)
        `OFS_FIFO_CONTROL: rdata_o <= fifo_control;
        `OFS_LINE_CONTROL: rdata_o <= line_control;
        `OFS_LINE_STATUS: rdata_o <= {1'b0, tx_empty_o, hold_empty_o, 5'h00};
        `OFS_DIVISOR_LOW: rdata_o <= divisor_low;
        `OFS_DIVISOR_HIGH_BYTE: rdata_o <= divisor_high_byte;
        `OFS_DIVISOR_FRACTION: rdata_o <= divisor_fraction;
        // write-only and unmapped offsets read as zero
        default: rdata_o <= 8'h00; // [RULE5]
      endcase
    end else begin
      // read data stands one cycle only
      rdata_o <= 8'h00;
    end
  end
endmodule // uart_tx

// ### uart_tx_consts.vh
// register offsets, field positions and reset values of the transmit path
// assumes a byte-wide register port with a 3-bit word address
`ifndef UART_TX_CONSTS_VH
`define UART_TX_CONSTS_VH

// ==========================================================
// register offsets
`define OFS_TRANSMIT_HOLDING 3'h0
`define OFS_FIFO_CONTROL 3'h1
`define OFS_LINE_CONTROL 3'h2
`define OFS_LINE_STATUS 3'h3
`define OFS_DIVISOR_LOW 3'h4
`define OFS_DIVISOR_HIGH_BYTE 3'h5
`define OFS_DIVISOR_FRACTION 3'h6

// ==========================================================
// reset values
`define RST_FIFO_CONTROL 8'h00
`define RST_LINE_CONTROL 8'h03
`define RST_DIVISOR_LOW 8'h01
`define RST_DIVISOR_HIGH_BYTE 8'h00
`define RST_DIVISOR_FRACTION 8'h00

// ==========================================================
// field positions
`define FC_FIFO_EN 0
`define LC_LEN_LO 0
`define LC_LEN_HI 1
`define LC_STOP2 2
`define LC_PAR_EN 3
`define LC_PAR_EVEN 4
`define LS_HOLD_EMPTY 5
`define LS_TX_EMPTY 6
`define DF_FRAC_HI 3
`define DF_FRAC_LO 0
`define DF_MODE_HI 5
`define DF_MODE_LO 4

// ==========================================================
// oversampling modes and ticks per bit
`define MODE_16X 2'h0
`define MODE_8X 2'h1
`define MODE_4X 2'h2
`define TICKS_16X 5'h10
`define TICKS_8X 5'h08
`define TICKS_4X 5'h04

// fraction steps per divisor unit
`define FRAC_STEPS 5'h10

`endif

// ### uart_tx_fifo.v
// synchronous first-in first-out store with valid/ready on both sides
// assumes one clock; flush empties it in one cycle
`timescale 1ns/10ps
module uart_tx_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  input wire clk_i,
  input wire rst_i,
  input wire flush_i,
  input wire in_valid_i,
  output wire in_ready_o,
  input wire [WIDTH-1:0] in_data_i,
  output wire out_valid_o,
  input wire out_ready_i,
  output wire [WIDTH-1:0] out_data_o,
  output wire [AW:0] count_o
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr;
  reg [AW-1:0] rd_ptr;
  reg [AW:0] count;
  wire push;
  wire pop;
  localparam [AW:0] FULL_COUNT = DEPTH[AW:0];
  localparam [AW-1:0] LAST_PTR = FULL_COUNT[AW-1:0] - 1'b1;

  assign in_ready_o = (count != FULL_COUNT);
  assign out_valid_o = (count != {(AW+1){1'b0}});
  assign out_data_o = mem[rd_ptr];
  assign count_o = count;
  assign push = in_valid_i && in_ready_o && !flush_i;
  assign pop = out_valid_o && out_ready_i && !flush_i;

  // ==========================================================
  // storage
  always @(posedge clk_i) begin
    if (push) begin
      mem[wr_ptr] <= in_data_i;
    end
  end

  // ==========================================================
  // pointers and fill level
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
    end else if (flush_i) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == LAST_PTR) ? {AW{1'b0}} : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == LAST_PTR) ? {AW{1'b0}} : rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule // uart_tx_fifo

// ### uart_tx_baud.v
// fractional divider making the oversampling tick
// assumes divisor = integer + fraction/16, integer 0 treated as 1
`timescale 1ns/10ps
`include "uart_tx_consts.vh"
module uart_tx_baud (
  input wire clk_i,
  input wire rst_i,
  input wire [15:0] div_int_i,
  input wire [3:0] div_frac_i,
  output reg tick_o
);
  reg [20:0] acc;
  wire [19:0] div_raw;
  wire [20:0] div16;
  wire [20:0] acc_step;

  assign div_raw = {div_int_i, div_frac_i};
  assign div16 = (div_int_i == 16'h0000) ? {16'h0000, `FRAC_STEPS} : {1'b0, div_raw};
  assign acc_step = acc + {16'h0000, `FRAC_STEPS};

  // ==========================================================
  // accumulate 16 per clock, tick each time divisor*16 is reached
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      acc <= 21'h00000;
      tick_o <= 1'b0;
    end else if (acc_step >= div16) begin
      acc <= acc_step - div16; // [RULE9]
      tick_o <= 1'b1;
    end else begin
      acc <= acc_step;
      tick_o <= 1'b0;
    end
  end
endmodule // uart_tx_baud

// ### uart_tx_monitor.sv
// checker on the transmit path ports
// assumes bound to uart_tx: one clock, asynchronous active-high reset
`timescale 1ns/10ps
module uart_tx_monitor #(
  parameter FIFO_DEPTH = 16,
  parameter FIFO_AW = 4
) (
  input wire clk_i,
  input wire rst_i,
  input wire [2:0] addr_i,
  input wire [7:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  input wire [7:0] rdata_o,
  input wire tx_o,
  input wire hold_empty_o,
  input wire tx_empty_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // ==========================================================
  // line level and bit lengths
  idle_high_a: assert property (tx_empty_o |-> tx_o)
    else $error("line low while idle");
  busy_low_a: assert property (!tx_o |-> !tx_empty_o)
    else $error("empty flag during a low bit");
  low_min_a: assert property ($fell(tx_o) |-> !tx_o [*4])
    else $error("low bit shorter than four ticks");
  high_min_a: assert property ($rose(tx_o) |-> tx_o [*4])
    else $error("high bit shorter than four ticks");
  start_soon_a: assert property (wr_i && addr_i == 3'h0 && tx_empty_o |-> ##[2:200] !tx_o)
    else $error("no start bit after write");
  reset_out_a: assert property ($fell(rst_i) |-> tx_o && hold_empty_o && tx_empty_o)
    else $error("outputs wrong after reset");
  // ==========================================================
  // status and register port
  flag_order_a: assert property (tx_empty_o |-> hold_empty_o)
    else $error("shifter empty flag without store empty");
  write_busy_a: assert property (wr_i && addr_i == 3'h0 && hold_empty_o |=> !tx_empty_o)
    else $error("accepted byte not seen");
  status_read_a: assert property ($past(rd_i) && $past(addr_i) == 3'h3
    |-> rdata_o[6:5] == {$past(tx_empty_o), $past(hold_empty_o)})
    else $error("status bits differ from flags");
  hold_read_a: assert property ($past(rd_i) && $past(addr_i) == 3'h0 |-> rdata_o == 8'h00)
    else $error("holding register read back");
  cover property (wr_i && addr_i == 3'h0);
  cover property (rd_i && addr_i == 3'h3);
  cover property ($fell(tx_o));
endmodule // uart_tx_monitor

bind uart_tx uart_tx_monitor #(.FIFO_DEPTH(FIFO_DEPTH), .FIFO_AW(FIFO_AW)) mon (
  .clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
  .rd_i(rd_i), .rdata_o(rdata_o), .tx_o(tx_o), .hold_empty_o(hold_empty_o),
  .tx_empty_o(tx_empty_o));

// ### uart_rx_model.sv
// remote receiver sampling the serial line at mid-bit
// assumes the bench gives the bit length as a whole number of clocks
`timescale 1ns/10ps
module uart_rx_model (
  input wire clk_i,
  input wire line_i,
  input int bit_clks,
  input int nbits,
  input bit par_en,
  input bit par_even,
  input int nstops,
  output logic [7:0] data_o,
  output logic err_o,
  output int count_o
);
  logic [7:0] d;
  logic e;
  initial begin
    data_o = 8'h00;
    err_o = 1'b0;
    forever begin
      @(negedge line_i);
      repeat (bit_clks / 2) @(posedge clk_i);
      e = line_i;
      d = 8'h00;
      for (int i = 0; i < nbits; i++) begin
        repeat (bit_clks) @(posedge clk_i);
        d[i] = line_i;
      end
      if (par_en) begin
        repeat (bit_clks) @(posedge clk_i);
        e = e | ((^d ^ line_i) == par_even);
      end
      for (int i = 0; i < nstops; i++) begin
        repeat (bit_clks) @(posedge clk_i);
        e = e | !line_i;
      end
      data_o = d;
      err_o = e;
      count_o++;
    end
  end
endmodule // uart_rx_model

// ### test_uart_transmitter_baud_divisor.sv
// self-checking bench for the transmit path
// assumes uart_tx, the receiver model and the bound checker
`timescale 1ns/10ps
module test_uart_transmitter_baud_divisor;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [2:0] addr_i = 3'h0;
  logic [7:0] wdata_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  wire [7:0] rdata_o;
  wire tx_o;
  wire hold_empty_o;
  wire tx_empty_o;
  wire [7:0] rx_d;
  wire rx_e;
  int rx_n;
  int bitc = 16, nb = 8, ns = 1, fail_count = 0, cmp_count = 0, seed = 18, n;
  bit pe = 0, ev = 0, arm = 0;
  real tf, te;
  logic [7:0] q[$];
  always #2.5 clk_i = ~clk_i;
  uart_tx dut (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .tx_o(tx_o),
    .hold_empty_o(hold_empty_o), .tx_empty_o(tx_empty_o));
  uart_rx_model far (.clk_i(clk_i), .line_i(tx_o), .bit_clks(bitc), .nbits(nb),
    .par_en(pe), .par_even(ev), .nstops(ns), .data_o(rx_d), .err_o(rx_e), .count_o(rx_n));
  task check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task results;
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // ==========================================================
  // register port cycles
  task wr(input logic [2:0] a, input logic [7:0] d);
    wr_i <= 1'b1;
    rd_i <= 1'b0;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_i);
    wr_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task rd(input logic [2:0] a, input logic [7:0] exp);
    rd_i <= 1'b1;
    wr_i <= 1'b0;
    addr_i <= a;
    @(posedge clk_i);
    rd_i <= 1'b0;
    @(negedge clk_i);
    check(rdata_o, exp);
    @(posedge clk_i);
  endtask
  // clocks per serial bit: divisor times ticks per bit, mode 11 as 16
  function automatic int bit_len(input logic [7:0] dl, input logic [7:0] df);
    int tpb;
    tpb = (df[5:4] == 2'h1) ? 8 : (df[5:4] == 2'h2) ? 4 : 16;
    return (dl * 16 + df[3:0]) * tpb / 16;
  endfunction
  task cfg(input logic [7:0] lc, input logic [7:0] dl, input logic [7:0] df, input bit fe);
    wr(3'h2, lc);
    wr(3'h4, dl);
    wr(3'h5, 8'h00);
    wr(3'h6, df);
    wr(3'h1, {7'h00, fe});
    rd(3'h3, 8'h60);
    nb = lc[1:0] + 5;
    ns = lc[2] + 1;
    pe = lc[3];
    ev = lc[4];
    bitc = bit_len(dl, df);
  endtask
  // k writes in a row, acc of them expected to be taken
  task send(input int k, input int acc, input logic [7:0] st);
    int t;
    arm = 1;
    for (int i = 0; i < k; i++) begin
      n = $random(seed);
      wr(3'h0, n[7:0]);
      if (i < acc) q.push_back(n[7:0] & ((8'h01 << nb) - 8'h01));
    end
    repeat (4) @(posedge clk_i);
    rd(3'h3, st);
    t = 0;
    while (tx_empty_o !== 1'b1 && t < 20000) begin
      @(negedge clk_i);
      t++;
    end
    te = $realtime;
    check((te - tf) / 5.0 > acc * (1 + nb + pe + ns) * bitc - 3, 1);
    check((te - tf) / 5.0 < acc * (1 + nb + pe + ns) * bitc + 3, 1);
    @(posedge clk_i);
    rd(3'h3, 8'h60);
    check(q.size(), 0);
  endtask
  always @(negedge tx_o) if (arm) begin
    tf = $realtime;
    arm = 0;
  end
  always @(rx_n) begin
    @(negedge clk_i);
    check(rx_e, 1'b0);
    check(rx_d, q.size() > 0 ? q.pop_front() : 32'h100);
  end
  initial begin
    #100000;
    fail_count++;
    results;
  end
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd(3'h4, 8'h01);
    rd(3'h5, 8'h00);
    rd(3'h6, 8'h00);
    rd(3'h0, 8'h00);
    rd(3'h7, 8'h00);
    $display("reset test done");
    for (int m = 0; m < 4; m++) begin
      cfg(8'h03, 8'h01, {2'h0, m[1:0], 4'h0}, 1);
      send(3, 3, 8'h00);
      $display("mode test %0d done", m);
    end
    for (int j = 0; j < 4; j++) begin
      cfg(j == 0 ? 8'h00 : j == 1 ? 8'h0F : j == 2 ? 8'h1A : 8'h17, 8'h02, 8'h20, 1);
      send(3, 3, 8'h00);
      $display("format test %0d done", j);
    end
    cfg(8'h03, 8'h01, 8'h08, 1);
    send(2, 2, 8'h00);
    $display("fraction test done");
    cfg(8'h03, 8'h01, 8'h10, 1);
    send(20, 19, 8'h00);
    $display("fill test done");
    cfg(8'h03, 8'h01, 8'h20, 0);
    send(2, 1, 8'h20);
    $display("single stage test done");
    results;
  end
endmodule // test_uart_transmitter_baud_divisor
